// ---- rtl/tmr_timer.sv ----
// Operation
// - in timer mode the counter only counts down, on divided internal ticks
// - timer mode is entered by writing the timer setting to mode bits
// - period follows from tick source, divide ratio and reload value
// - count clock select field chooses tick source and division
// - underflow with reload select 1 loads the reload value
// - underflow with reload select 0 wraps the counter to ffff
// - gate select 0: counting follows the enable bit and sleep, not the input pin
// - gate select 1: counting needs enable set and input pin high
// - every underflow from zero raises the interrupt event
// - pulse output enabled: output pin toggles on each underflow
// - reading the count register returns the present count
// - soft reset bit copies the reload value into the counter at once
// - without soft reset a new reload value lands at next underflow
// - gated timer pauses while input low, resumes while high
// - output pin is driven low whenever enable is cleared
// - leaving sleep while enabled restarts counting from the reload value
// - timer event interrupt fires on counter underflow only while the mask bit is set
`timescale 1ns/10ps
module tmr_timer (
    // clock and reset
    input  wire logic                         clk_i,
    input  wire logic                         rst_n_i,
    // axi4-lite write address
    input  wire logic                         s_axi_awvalid_i,
    output logic                              s_axi_awready_o,
    input  wire logic [tmr_pkg::TMR_AXI_AW-1:0] s_axi_awaddr_i,
    // axi4-lite write data
    input  wire logic                         s_axi_wvalid_i,
    output logic                              s_axi_wready_o,
    input  wire logic [31:0]                  s_axi_wdata_i,
    input  wire logic [3:0]                   s_axi_wstrb_i,
    // axi4-lite write response
    output logic                              s_axi_bvalid_o,
    input  wire logic                         s_axi_bready_i,
    output logic [1:0]                        s_axi_bresp_o,
    // axi4-lite read address
    input  wire logic                         s_axi_arvalid_i,
    output logic                              s_axi_arready_o,
    input  wire logic [tmr_pkg::TMR_AXI_AW-1:0] s_axi_araddr_i,
    // axi4-lite read data
    output logic                              s_axi_rvalid_o,
    input  wire logic                         s_axi_rready_i,
    output logic [31:0]                       s_axi_rdata_o,
    output logic [1:0]                        s_axi_rresp_o,
    // power management
    input  wire logic                         sleep_en_i,
    // timer pins
    input  wire logic                         timer_input_pin_i,
    output logic                              timer_output_pin_o,
    // interrupt
    output logic                              timer_event_irq_o
);
    import tmr_pkg::*;

    typedef struct packed {
        logic                  awready;
        logic                  wready;
        logic                  bvalid;
        logic [1:0]            bresp;
        logic [TMR_AXI_AW-1:0] awaddr;
        logic [31:0]           wdata;
        logic [3:0]            wstrb;
        logic                  arready;
        logic                  rvalid;
        logic [31:0]           rdata;
        logic [1:0]            rresp;
        logic [7:0]            ctrl;
        logic [3:0]            clksel;
        logic [15:0]           reload;
        logic [15:0]           cnt;
        logic                  status;
        logic                  mask;
        logic                  irq;
        logic                  timer_output_level;
        logic                  tin_s1;
        logic                  tin_s2;
        logic                  tin_s3;
        logic                  tin_lvl;
        logic                  sleep;
    } tmr_st_t;

    localparam tmr_st_t TMR_ST_RST = '{
        awready: 1'b1, wready: 1'b1, bvalid: 1'b0, bresp: TMR_RESP_OKAY,
        awaddr: '0, wdata: '0, wstrb: '0,
        arready: 1'b1, rvalid: 1'b0, rdata: '0, rresp: TMR_RESP_OKAY,
        ctrl: TMR_CTRL_RST, clksel: TMR_CLKSEL_RST,
        reload: TMR_RELOAD_RST, cnt: TMR_COUNT_RST,
        status: TMR_STATUS_RST, mask: TMR_MASK_RST, irq: 1'b0,
        timer_output_level: 1'b0, tin_s1: 1'b0, tin_s2: 1'b0, tin_s3: 1'b0,
        tin_lvl: 1'b0, sleep: 1'b0
    };

    tmr_st_t     q;
    tmr_st_t     d;
    logic        wr_fire;
    logic [31:0] wr_word;
    logic        sw_rst;
    logic        run;
    logic        wake;
    logic        uf;
    logic        w1c;
    tmr_mode_t   mode;

    tmr_tick_if tk ();

    // prescaler turns the fast clock into the count tick
    tmr_presc #(
        .DIV_LOG (TMR_DIV_LOG)
    ) u_presc (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .tk      (tk)
    );

    assign tk.sel     = q.clksel;
    assign tk.restart = sw_rst;

    // mode decode: only timer mode runs this counter
    always_comb begin
        mode = tmr_mode_t'(q.ctrl[TMR_CTRL_MODE_LSB +: 2]);
        case (mode)
            TMR_MODE_TIMER: begin
                run = q.ctrl[TMR_CTRL_EN] && !q.sleep &&
                      (!q.ctrl[TMR_CTRL_GATE] || q.tin_lvl);
            end
            default: begin
                run = 1'b0;
            end
        endcase
    end

    // the write takes effect once both address and data are held
    assign wr_fire = !q.awready && !q.wready && !q.bvalid;
    assign sw_rst  = wr_fire && (q.awaddr == TMR_OFS_CTRL) &&
                     q.wstrb[0] && q.wdata[TMR_CTRL_SWRST];
    assign w1c     = wr_fire && (q.awaddr == TMR_OFS_STATUS) &&
                     q.wstrb[0] && q.wdata[0];
    assign wake    = q.sleep && !sleep_en_i && q.ctrl[TMR_CTRL_EN];

    always_comb begin
        d       = q;
        wr_word = '0;
        uf      = 1'b0;

        // three-stage pin sync; a change counts once stages two and three agree
        d.tin_s1 = timer_input_pin_i;
        d.tin_s2 = q.tin_s1;
        d.tin_s3 = q.tin_s2;
        if (q.tin_s2 == q.tin_s3) begin
            d.tin_lvl = q.tin_s3;
        end
        d.sleep = sleep_en_i;

        // write address and data channels, taken in either order
        if (q.awready && s_axi_awvalid_i) begin
            d.awready = 1'b0;
            d.awaddr  = s_axi_awaddr_i;
        end
        if (q.wready && s_axi_wvalid_i) begin
            d.wready = 1'b0;
            d.wdata  = s_axi_wdata_i;
            d.wstrb  = s_axi_wstrb_i;
        end
        if (wr_fire) begin
            d.bvalid = 1'b1;
            d.bresp  = tmr_hit(q.awaddr) ? TMR_RESP_OKAY : TMR_RESP_SLVERR;
            case (q.awaddr)
                TMR_OFS_CTRL: begin
                    wr_word = tmr_merge({24'h0, q.ctrl}, q.wdata, q.wstrb);
                    d.ctrl  = wr_word[7:0] & TMR_CTRL_WMASK;
                end
                TMR_OFS_CLKSEL: begin
                    wr_word  = tmr_merge({28'h0, q.clksel}, q.wdata, q.wstrb);
                    d.clksel = wr_word[3:0];
                end
                TMR_OFS_RELOAD: begin
                    wr_word  = tmr_merge({16'h0, q.reload}, q.wdata, q.wstrb);
                    d.reload = wr_word[15:0];
                end
                TMR_OFS_MASK: begin
                    wr_word = tmr_merge({31'h0, q.mask}, q.wdata, q.wstrb);
                    d.mask  = wr_word[0];
                end
                default: begin
                    wr_word = '0;
                end
            endcase
        end
        if (q.bvalid && s_axi_bready_i) begin
            d.bvalid  = 1'b0;
            d.awready = 1'b1;
            d.wready  = 1'b1;
        end

        // read channel; reads only sample state, nothing is cleared
        if (q.arready && s_axi_arvalid_i) begin
            d.arready = 1'b0;
            d.rvalid  = 1'b1;
            d.rresp   = tmr_hit(s_axi_araddr_i) ? TMR_RESP_OKAY
                                                : TMR_RESP_SLVERR;
            case (s_axi_araddr_i)
                TMR_OFS_CTRL:   d.rdata = {24'h0, q.ctrl};
                TMR_OFS_CLKSEL: d.rdata = {28'h0, q.clksel};
                TMR_OFS_RELOAD: d.rdata = {16'h0, q.reload};
                TMR_OFS_COUNT:  d.rdata = {16'h0, q.cnt};
                TMR_OFS_STATUS: d.rdata = {31'h0, q.status};
                TMR_OFS_MASK:   d.rdata = {31'h0, q.mask};
                default:        d.rdata = 32'h0;
            endcase
        end
        if (q.rvalid && s_axi_rready_i) begin
            d.rvalid  = 1'b0;
            d.arready = 1'b1;
        end

        // counter: soft reset first, then wake from sleep, then counting
        if (sw_rst) begin
            d.cnt = q.reload;
        end else if (wake) begin
            d.cnt = q.reload;
        end else if (run && tk.tick) begin
            if (q.cnt == TMR_ZERO_VAL) begin
                uf = 1'b1;
                if (q.ctrl[TMR_CTRL_RL]) begin
                    d.cnt = q.reload;
                end else begin
                    d.cnt = TMR_WRAP_VAL;
                end
            end else begin
                d.cnt = q.cnt - 16'h0001;
            end
        end

        // sticky event: a new underflow beats a same-cycle clear
        d.status = (q.status && !w1c) || uf;
        d.irq    = q.status && q.mask;

        // pulse output: toggles on underflow, forced low when disabled
        if (!q.ctrl[TMR_CTRL_EN]) begin
            d.timer_output_level = 1'b0;
        end else if (uf && q.ctrl[TMR_CTRL_PULSE]) begin
            d.timer_output_level = !q.timer_output_level;
        end
    end

    // synchronous reset; all state in one register
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            q <= TMR_ST_RST;
        end else begin
            q <= d;
        end
    end

    // outputs straight from state flip-flops
    assign s_axi_awready_o    = q.awready;
    assign s_axi_wready_o     = q.wready;
    assign s_axi_bvalid_o     = q.bvalid;
    assign s_axi_bresp_o      = q.bresp;
    assign s_axi_arready_o    = q.arready;
    assign s_axi_rvalid_o     = q.rvalid;
    assign s_axi_rdata_o      = q.rdata;
    assign s_axi_rresp_o      = q.rresp;
    assign timer_output_pin_o = q.timer_output_level;
    assign timer_event_irq_o  = q.irq;

    // checks on the counter, pin and interrupt behaviour
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_count_step;
        run && tk.tick && !sw_rst && !wake;
    endsequence

    sequence s_underflow;
        s_count_step ##0 (q.cnt == 16'h0000);
    endsequence

    AST_DOWN_ONLY: assert property (
        (s_count_step ##0 (q.cnt != 16'h0000)) |=>
            (q.cnt == $past(q.cnt) - 16'h0001))
        else $error("counter did not step down by one");

    AST_RELOAD_LOAD: assert property (
        (s_underflow ##0 q.ctrl[4]) |=> (q.cnt == $past(q.reload)))
        else $error("underflow did not load the reload value");

    AST_WRAP: assert property (
        (s_underflow ##0 !q.ctrl[4]) |=> (q.cnt == 16'hffff))
        else $error("free-running underflow did not wrap to ffff");

    AST_HOLD: assert property (
        (!run && !sw_rst && !wake) |=> $stable(q.cnt))
        else $error("counter moved while halted or gated");

    AST_GATE: assert property (
        (q.ctrl[5] && !q.tin_lvl && !sw_rst && !wake) |=> $stable(q.cnt))
        else $error("gated counter moved with input low");

    AST_EVENT: assert property (
        s_underflow |=> q.status ##1 (timer_event_irq_o == $past(q.mask)))
        else $error("underflow did not raise the event");

    AST_TOGGLE: assert property (
        (s_underflow ##0 q.ctrl[6] && q.ctrl[0]) |=>
            (timer_output_pin_o != $past(timer_output_pin_o)))
        else $error("output pin did not toggle on underflow");

    AST_OUT_LOW: assert property (
        !q.ctrl[0] |=> !timer_output_pin_o)
        else $error("output pin high while disabled");

    AST_SOFT_RST: assert property (
        sw_rst |=> (q.cnt == $past(q.reload)) && s_axi_bvalid_o)
        else $error("soft reset did not copy the reload value");

    AST_WAKE: assert property (
        (wake && !sw_rst) |=> (q.cnt == $past(q.reload)))
        else $error("wake from sleep did not restart from reload");

    // register side: other modes, reserved selects, reads and the flag
    AST_MODE_HALT: assert property (
        (mode != TMR_MODE_TIMER && !sw_rst && !wake) |=> $stable(q.cnt))
        else $error("counter moved outside timer mode");

    AST_RESV_SEL: assert property (
        q.clksel[3] |-> !tk.tick)
        else $error("reserved clock select produced a tick");

    AST_COUNT_READ: assert property (
        (q.arready && s_axi_arvalid_i && (s_axi_araddr_i == TMR_OFS_COUNT))
            |=> (s_axi_rdata_o == {16'h0000, $past(q.cnt)}))
        else $error("count read did not return the present count");

    AST_STICKY: assert property (
        (q.status && !w1c) |=> q.status)
        else $error("event flag dropped without a clear");

    AST_IRQ_MASKED: assert property (
        !q.mask |=> !timer_event_irq_o)
        else $error("interrupt raised while masked");

endmodule

// ---- rtl/tmr_pkg.sv ----
package tmr_pkg;

    // register map, byte addresses on the AXI4-Lite slave
    localparam int unsigned TMR_AXI_AW      = 8;
    localparam logic [7:0]  TMR_OFS_CTRL    = 8'h00;
    localparam logic [7:0]  TMR_OFS_CLKSEL  = 8'h04;
    localparam logic [7:0]  TMR_OFS_RELOAD  = 8'h08;
    localparam logic [7:0]  TMR_OFS_COUNT   = 8'h0c;
    localparam logic [7:0]  TMR_OFS_STATUS  = 8'h10;
    localparam logic [7:0]  TMR_OFS_MASK    = 8'h14;

    // control register fields
    localparam int unsigned TMR_CTRL_EN       = 0;
    localparam int unsigned TMR_CTRL_MODE_LSB = 2;
    localparam int unsigned TMR_CTRL_RL       = 4;
    localparam int unsigned TMR_CTRL_GATE     = 5;
    localparam int unsigned TMR_CTRL_PULSE    = 6;
    localparam int unsigned TMR_CTRL_SWRST    = 7;
    localparam logic [7:0]  TMR_CTRL_WMASK    = 8'h7d;

    // widths
    localparam int unsigned TMR_CNT_W      = 16;
    localparam int unsigned TMR_CLKSEL_W   = 4;
    localparam int unsigned TMR_DIV_LOG    = 7;

    // reset and fixed values
    localparam logic [7:0]  TMR_CTRL_RST   = 8'h00;
    localparam logic [3:0]  TMR_CLKSEL_RST = 4'h0;
    localparam logic [15:0] TMR_RELOAD_RST = 16'hffff;
    localparam logic [15:0] TMR_COUNT_RST  = 16'hffff;
    localparam logic [15:0] TMR_WRAP_VAL   = 16'hffff;
    localparam logic [15:0] TMR_ZERO_VAL   = 16'h0000;
    localparam logic        TMR_STATUS_RST = 1'b0;
    localparam logic        TMR_MASK_RST   = 1'b0;

    // bus responses
    localparam logic [1:0]  TMR_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  TMR_RESP_SLVERR = 2'h2;

    // operating modes held in the control register
    typedef enum logic [1:0] {
        TMR_MODE_TIMER   = 2'b00,
        TMR_MODE_EVENT   = 2'b01,
        TMR_MODE_ONESHOT = 2'b10,
        TMR_MODE_MEAS    = 2'b11
    } tmr_mode_t;

    // merge a bus write into a word under its byte strobes
    function automatic logic [31:0] tmr_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // true when an address names one of the registers
    function automatic logic tmr_hit(input logic [7:0] a);
        return (a == TMR_OFS_CTRL)   || (a == TMR_OFS_CLKSEL) ||
               (a == TMR_OFS_RELOAD) || (a == TMR_OFS_COUNT)  ||
               (a == TMR_OFS_STATUS) || (a == TMR_OFS_MASK);
    endfunction

endpackage

// ---- rtl/tmr_tick_if.sv ----
`timescale 1ns/10ps
// count clock select and the divided tick between timer and prescaler
interface tmr_tick_if;
    logic [3:0] sel;
    logic       restart;
    logic       tick;

    modport ctl   (output sel, output restart, input tick);
    modport presc (input sel, input restart, output tick);
endinterface

// ---- rtl/tmr_presc.sv ----
`timescale 1ns/10ps
module tmr_presc #(
    parameter int unsigned DIV_LOG = tmr_pkg::TMR_DIV_LOG
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    // tick towards the counter
    tmr_tick_if.presc tk
);
    import tmr_pkg::*;

    typedef struct packed {
        logic [DIV_LOG-1:0] cnt;
    } tmr_presc_st_t;

    tmr_presc_st_t      q;
    tmr_presc_st_t      d;
    logic [DIV_LOG-1:0] mask;

    // the largest divide needs seven counter bits
    if (DIV_LOG < TMR_DIV_LOG) begin : g_chk
        $error("tmr_presc: DIV_LOG too small for divide by 128");
    end

    // selects 1xxx are reserved and never tick, so the counter halts
    always_comb begin
        d    = q;
        mask = DIV_LOG'((32'h1 << tk.sel[2:0]) - 32'h1);
        if (tk.restart) begin
            d.cnt = '0;
        end else begin
            d.cnt = DIV_LOG'(q.cnt + 1'b1);
        end
    end

    // free-running counter: tick when its low sel bits are all ones
    assign tk.tick = !tk.sel[3] && ((q.cnt & mask) == mask);

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

endmodule

// ---- tb/tb_tmr_timer.sv ----
`timescale 1ns/10ps
module tb_tmr_timer;
    import tmr_pkg::*;

    // control word pieces
    localparam logic [31:0] C_EN = 32'h1 << TMR_CTRL_EN;
    localparam logic [31:0] C_RL = 32'h1 << TMR_CTRL_RL;
    localparam logic [31:0] C_GT = 32'h1 << TMR_CTRL_GATE;
    localparam logic [31:0] C_PU = 32'h1 << TMR_CTRL_PULSE;
    localparam logic [31:0] C_SR = 32'h1 << TMR_CTRL_SWRST;
    localparam logic [7:0]  OFS [6] = '{TMR_OFS_CTRL, TMR_OFS_CLKSEL,
        TMR_OFS_RELOAD, TMR_OFS_COUNT, TMR_OFS_STATUS, TMR_OFS_MASK};
    localparam logic [31:0] RSTV [6] = '{32'h0, 32'h0, 32'hffff,
        32'hffff, 32'h0, 32'h0};

    // bench signals
    logic        clk_i;
    logic        rst_n_i;
    logic        awvalid;
    logic        awready;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic        wready;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic        bready;
    logic [1:0]  bresp;
    logic        arvalid;
    logic        arready;
    logic [7:0]  araddr;
    logic        rvalid;
    logic        rready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        sleep_en;
    logic        timer_input_level;
    logic        timer_output_level;
    logic        irq;
    logic [1:0]  last_resp;
    int          fails;
    int          n_compared;

    tmr_timer dut_u (
        .clk_i             (clk_i),
        .rst_n_i           (rst_n_i),
        .s_axi_awvalid_i   (awvalid),
        .s_axi_awready_o   (awready),
        .s_axi_awaddr_i    (awaddr),
        .s_axi_wvalid_i    (wvalid),
        .s_axi_wready_o    (wready),
        .s_axi_wdata_i     (wdata),
        .s_axi_wstrb_i     (wstrb),
        .s_axi_bvalid_o    (bvalid),
        .s_axi_bready_i    (bready),
        .s_axi_bresp_o     (bresp),
        .s_axi_arvalid_i   (arvalid),
        .s_axi_arready_o   (arready),
        .s_axi_araddr_i    (araddr),
        .s_axi_rvalid_o    (rvalid),
        .s_axi_rready_i    (rready),
        .s_axi_rdata_o     (rdata),
        .s_axi_rresp_o     (rresp),
        .sleep_en_i        (sleep_en),
        .timer_input_pin_i (timer_input_level),
        .timer_output_pin_o(timer_output_level),
        .timer_event_irq_o (irq)
    );

    // 20 mhz clock
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    // compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // a spent wait counts as a mismatch
    task automatic timed_out();
        fails++;
        $display("BAD t=%0t seen=%h exp=%h", $time, 32'h0, 32'h1);
        give_verdict();
    endtask

    task automatic end_test(input string name);
        $display("test %s done, mismatches so far %0d", name, fails);
    endtask

    // axi write; one idle edge at the end so no strobe is set twice
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int k;
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid && k < 64);
        last_resp = bresp;
        bready <= 1'b0;
        if (k >= 64) timed_out();
        @(posedge clk_i);
    endtask

    // axi read
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        int k;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid && k < 64);
        d = rdata;
        last_resp = rresp;
        rready <= 1'b0;
        if (k >= 64) timed_out();
        @(posedge clk_i);
    endtask

    // cycles until the pulse output changes level
    task automatic wait_tog(output int n);
        logic p;
        p = timer_output_level;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (timer_output_level === p && n < 2000);
        if (n >= 2000) timed_out();
    endtask

    // count must stand still across 40 cycles and two reads
    task automatic hold_chk(input logic [31:0] exp);
        logic [31:0] d;
        rd(TMR_OFS_COUNT, d);
        chk(d, exp);
        repeat (40) @(posedge clk_i);
        rd(TMR_OFS_COUNT, d);
        chk(d, exp);
    endtask

    // whole-run guard against a hang
    initial begin
        repeat (100000) @(posedge clk_i);
        timed_out();
    end

    initial begin
        logic [31:0] d;
        logic [31:0] d2;
        int          m;
        rst_n_i <= 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} <= 5'h00;
        awaddr <= 8'h00;
        araddr <= 8'h00;
        wdata <= 32'h0;
        wstrb <= 4'h0;
        sleep_en <= 1'b0;
        timer_input_level <= 1'b0;
        fails = 0;
        n_compared = 0;
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);

        // reset values, read-only count, unmapped place, reserved bit
        foreach (OFS[i]) begin
            rd(OFS[i], d);
            chk(d, RSTV[i]);
        end
        chk({31'h0, timer_output_level}, 32'h0);
        wr(TMR_OFS_COUNT, 32'h0);
        rd(TMR_OFS_COUNT, d);
        chk(d, 32'hffff);
        wr(8'h18, 32'h1);
        chk(32'(last_resp), 32'(TMR_RESP_SLVERR));
        rd(8'h18, d);
        chk({d[29:0], last_resp}, 32'(TMR_RESP_SLVERR));
        wr(TMR_OFS_CTRL, 32'h2);
        rd(TMR_OFS_CTRL, d);
        chk(d, 32'h0);
        end_test("bus");

        // pulse period is three ticks of two to the select cycles
        wr(TMR_OFS_RELOAD, 32'h2);
        wr(TMR_OFS_MASK, 32'h1);
        for (int n = 0; n < 8; n++) begin
            wr(TMR_OFS_CLKSEL, 32'(n));
            wr(TMR_OFS_CTRL, C_EN | C_RL | C_PU | C_SR);
            wait_tog(m);
            wait_tog(m);
            chk(32'(m), 32'(3 << n));
        end
        chk({31'h0, irq}, 32'h1);
        wr(TMR_OFS_CLKSEL, 32'h8);
        wr(TMR_OFS_CTRL, C_EN | C_RL | C_PU | C_SR);
        hold_chk(32'h2);
        end_test("period");

        // reload against wrap, status sticky, mask gates the irq
        wr(TMR_OFS_CLKSEL, 32'h7);
        wr(TMR_OFS_RELOAD, 32'h5);
        for (int rl = 0; rl < 2; rl++) begin
            wr(TMR_OFS_MASK, 32'(rl));
            wr(TMR_OFS_STATUS, 32'h1);
            wr(TMR_OFS_CTRL, C_EN | C_PU | C_SR | (rl != 0 ? C_RL : 32'h0));
            wait_tog(m);
            rd(TMR_OFS_COUNT, d);
            chk(d, rl != 0 ? 32'h5 : 32'hffff);
            rd(TMR_OFS_STATUS, d);
            chk(d, 32'h1);
            chk({31'h0, irq}, 32'(rl));
        end
        wr(TMR_OFS_STATUS, 32'h1);
        rd(TMR_OFS_STATUS, d);
        chk(d, 32'h0);
        chk({31'h0, irq}, 32'h0);
        end_test("underflow");

        // a new reload value waits for the next underflow
        wr(TMR_OFS_RELOAD, 32'h40);
        rd(TMR_OFS_COUNT, d);
        chk({31'h0, d < 32'h6}, 32'h1);
        wait_tog(m);
        rd(TMR_OFS_COUNT, d);
        chk(d, 32'h40);
        end_test("late_reload");

        // sleep halts the count, waking restarts from reload
        sleep_en <= 1'b1;
        repeat (4) @(posedge clk_i);
        rd(TMR_OFS_COUNT, d);
        repeat (300) @(posedge clk_i);
        rd(TMR_OFS_COUNT, d2);
        chk(d2, d);
        sleep_en <= 1'b0;
        repeat (2) @(posedge clk_i);
        rd(TMR_OFS_COUNT, d);
        chk({31'h0, d == 32'h40 || d == 32'h3f}, 32'h1);
        end_test("sleep");

        // disabled: pin low, soft reset loads at once, reads harmless
        wr(TMR_OFS_CTRL, C_RL | C_PU);
        chk({31'h0, timer_output_level}, 32'h0);
        wr(TMR_OFS_RELOAD, 32'h1234);
        wr(TMR_OFS_CTRL, C_RL | C_PU | C_SR);
        hold_chk(32'h1234);
        // pin low while disabled; the earlier underflow still holds the irq
        chk({30'h0, timer_output_level, irq}, 32'h1);
        end_test("soft_reset");

        // gate pin pauses and resumes counting
        wr(TMR_OFS_CLKSEL, 32'h0);
        wr(TMR_OFS_CTRL, C_EN | C_RL | C_GT);
        hold_chk(32'h1234);
        timer_input_level <= 1'b1;
        repeat (20) @(posedge clk_i);
        rd(TMR_OFS_COUNT, d);
        rd(TMR_OFS_COUNT, d2);
        chk({31'h0, d2 < d && d < 32'h1234}, 32'h1);
        timer_input_level <= 1'b0;
        repeat (10) @(posedge clk_i);
        rd(TMR_OFS_COUNT, d);
        hold_chk(d);
        end_test("gate");

        // modes other than timer keep the counter still
        timer_input_level <= 1'b1;
        for (int md = 1; md < 4; md++) begin
            wr(TMR_OFS_CTRL, C_EN | C_RL | C_SR | (32'(md) << 2));
            hold_chk(32'h1234);
        end
        end_test("modes");
        give_verdict();
    end
endmodule
